/* verilog/sen_top.sv */
// system error collection and nmi/serr reporting, ahb-lite register slave
// assumes all inputs synchronous to i_clk_sys; serr/perr pins resolved outside
//
// Behaviour
// - control port bit 7 reads 1 after a memory parity error.
// - control port bit 6 reads 1 after a channel check assertion.
// - control port bit 3 enables channel check reporting.
// - control port bit 2 enables system board parity reporting.
// - nmi raised on enabled memory error or channel check.
// - index port bit 7 masks nmi delivery to the processor.
// - error command bit 4 enables serr on target abort.
// - error command bit 3 enables serr on pci parity error.
// - error command bit 1 enables serr on multi-bit memory error.
// - error command bit 0 enables serr on single-bit memory error.
// - error status bit 4 records a multi-bit memory error.
// - error status bit 0 records a single-bit memory error.
// - this bridge drives serr for errors on the first pci bus.
// - non-parity pci errors are reported straight on serr.
// - serr can be routed onto the processor nmi.
// - secondary serr is repeated on the primary serr.
// - secondary perr is repeated on the primary perr.
// - processor bus parity and fatal faults are never reported.
`timescale 1ns/1ps
`include "sen_defs.svh"

module sen_top (
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic [31:0] o_hrdata,
    input wire logic i_iochk_n,
    input wire logic i_mem_parity_err,
    input wire logic i_pci_target_abort,
    input wire logic i_pci_parity_err,
    input wire logic i_ecc_sbe,
    input wire logic i_ecc_mbe,
    input wire logic [2:0] i_ecc_row,
    input wire logic i_sec_serr_n,
    input wire logic i_sec_perr_n,
    output logic o_serr_o,
    output logic o_serr_oe_n,
    output logic o_perr_o,
    output logic o_perr_oe_n,
    output logic o_nmi
);

    // ============================================================
    // decode helper
    function automatic logic sen_hit(input logic [9:0] idx, input logic [9:0] want);
        sen_hit = (idx == want);
    endfunction : sen_hit

    // ============================================================
    // bus slave
    sen_pkg::sen_bus_st_t st_reg, st_next;
    logic [9:0] idx_reg, idx_next;
    logic wr_reg, wr_next;
    logic hreadyout_reg, hreadyout_next;
    logic [31:0] hrdata_reg, hrdata_next;
    logic wr_now;
    logic [7:0] wdat;
    logic [7:0] rbyte;

    sen_pkg::sen_byte_t cmd_lo_reg, cmd_lo_next;
    sen_pkg::sen_byte_t cmd_hi_reg, cmd_hi_next;
    sen_pkg::sen_byte_t sys_ctrl_reg, sys_ctrl_next;
    sen_pkg::sen_byte_t nmi_ctrl_reg, nmi_ctrl_next;
    sen_pkg::sen_byte_t err_cmd_reg, err_cmd_next;
    sen_pkg::sen_byte_t err_stat_reg, err_stat_next;
    sen_pkg::sen_byte_t route_reg, route_next;
    sen_pkg::sen_byte_t pci_stat_reg, pci_stat_next;

    // one wait state per transfer: a read never sees a stale byte
    // after a write in the transfer before it
    always_comb begin
        st_next = st_reg;
        idx_next = idx_reg;
        wr_next = wr_reg;
        hreadyout_next = 1'b1;
        hrdata_next = hrdata_reg;
        wr_now = 1'b0;
        unique case (st_reg)
            sen_pkg::SEN_ST_IDLE: begin
                if (i_hsel && i_htrans[1] && i_hready) begin
                    idx_next = i_haddr[11:2];
                    wr_next = i_hwrite;
                    hreadyout_next = 1'b0;
                    st_next = sen_pkg::SEN_ST_DATA;
                end
            end
            sen_pkg::SEN_ST_DATA: begin
                wr_now = wr_reg;
                hrdata_next = {24'h000000, rbyte};
                st_next = sen_pkg::SEN_ST_IDLE;
            end
            default: begin
                st_next = sen_pkg::SEN_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            st_reg <= sen_pkg::SEN_ST_IDLE;
            idx_reg <= 10'h000;
            wr_reg <= 1'b0;
            hreadyout_reg <= 1'b1;
            hrdata_reg <= 32'h00000000;
        end else begin
            st_reg <= st_next;
            idx_reg <= idx_next;
            wr_reg <= wr_next;
            hreadyout_reg <= hreadyout_next;
            hrdata_reg <= hrdata_next;
        end
    end

    assign wdat = i_hwdata[7:0];

    // unmapped indices read as zero and ignore writes
    always_comb begin
        rbyte = 8'h00;
        if (sen_hit(idx_reg, `SEN_IDX_PCI_CMD_LO)) begin
            rbyte = cmd_lo_reg;
        end else if (sen_hit(idx_reg, `SEN_IDX_PCI_CMD_HI)) begin
            rbyte = cmd_hi_reg;
        end else if (sen_hit(idx_reg, `SEN_IDX_SYS_CTRL)) begin
            rbyte = sys_ctrl_reg;
        end else if (sen_hit(idx_reg, `SEN_IDX_NMI_CTRL)) begin
            rbyte = nmi_ctrl_reg;
        end else if (sen_hit(idx_reg, `SEN_IDX_ERR_CMD)) begin
            rbyte = err_cmd_reg;
        end else if (sen_hit(idx_reg, `SEN_IDX_ERR_STAT)) begin
            rbyte = err_stat_reg;
        end else if (sen_hit(idx_reg, `SEN_IDX_ERR_ROUTE)) begin
            rbyte = route_reg;
        end else if (sen_hit(idx_reg, `SEN_IDX_PCI_STAT)) begin
            rbyte = pci_stat_reg;
        end
    end

    // ============================================================
    // error registers
    logic mem_evt;
    logic chk_en;
    logic par_en;
    logic sc_wr;
    logic es_wr;
    logic ps_wr;

    // ecc multi-bit errors stand in for legacy memory parity
    assign mem_evt = i_mem_parity_err | i_ecc_mbe;
    assign sc_wr = wr_now && sen_hit(idx_reg, `SEN_IDX_SYS_CTRL);
    assign es_wr = wr_now && sen_hit(idx_reg, `SEN_IDX_ERR_STAT);
    assign ps_wr = wr_now && sen_hit(idx_reg, `SEN_IDX_PCI_STAT);

    always_comb begin
        cmd_lo_next = cmd_lo_reg;
        cmd_hi_next = cmd_hi_reg;
        nmi_ctrl_next = nmi_ctrl_reg;
        err_cmd_next = err_cmd_reg;
        route_next = route_reg;
        if (wr_now && sen_hit(idx_reg, `SEN_IDX_PCI_CMD_LO)) begin
            cmd_lo_next = wdat;
        end
        if (wr_now && sen_hit(idx_reg, `SEN_IDX_PCI_CMD_HI)) begin
            cmd_hi_next = wdat;
        end
        if (wr_now && sen_hit(idx_reg, `SEN_IDX_NMI_CTRL)) begin
            nmi_ctrl_next = wdat;
        end
        if (wr_now && sen_hit(idx_reg, `SEN_IDX_ERR_CMD)) begin
            err_cmd_next = wdat;
        end
        if (wr_now && sen_hit(idx_reg, `SEN_IDX_ERR_ROUTE)) begin
            route_next = wdat & `SEN_RT_WR_MASK;
        end
    end

    // control port: enables writable, flags read only; a flag is held
    // until its enable is dropped, as legacy handlers expect
    always_comb begin
        sys_ctrl_next = sys_ctrl_reg;
        if (sc_wr) begin
            sys_ctrl_next = (sys_ctrl_reg & ~`SEN_SC_WR_MASK) | (wdat & `SEN_SC_WR_MASK);
        end
        chk_en = sys_ctrl_next[`SEN_SC_CHK_EN];
        par_en = sys_ctrl_next[`SEN_SC_PAR_EN];
        sys_ctrl_next[`SEN_SC_MEM_FLAG] = par_en & (sys_ctrl_reg[`SEN_SC_MEM_FLAG] | mem_evt);
        sys_ctrl_next[`SEN_SC_CHK_FLAG] = chk_en & (sys_ctrl_reg[`SEN_SC_CHK_FLAG] | ~i_iochk_n);
        sys_ctrl_next[5:4] = 2'b00;
        sys_ctrl_next[1:0] = 2'b00;
    end

    // status flags are write-one-to-clear; a new event beats the clear
    always_comb begin
        err_stat_next = err_stat_reg;
        pci_stat_next = pci_stat_reg;
        if (es_wr) begin
            err_stat_next[`SEN_ES_MBE] = err_stat_reg[`SEN_ES_MBE] & ~wdat[`SEN_ES_MBE];
            err_stat_next[`SEN_ES_SBE] = err_stat_reg[`SEN_ES_SBE] & ~wdat[`SEN_ES_SBE];
        end
        if (i_ecc_mbe) begin
            err_stat_next[`SEN_ES_MBE] = 1'b1;
            err_stat_next[`SEN_ES_MBE_ROW_HI:`SEN_ES_MBE_ROW_LO] = i_ecc_row;
        end
        if (i_ecc_sbe) begin
            err_stat_next[`SEN_ES_SBE] = 1'b1;
            err_stat_next[`SEN_ES_SBE_ROW_HI:`SEN_ES_SBE_ROW_LO] = i_ecc_row;
        end
        if (ps_wr) begin
            pci_stat_next = pci_stat_reg & ~wdat;
        end
        if (i_pci_target_abort) begin
            pci_stat_next[`SEN_PS_TABORT] = 1'b1;
        end
        if (i_pci_parity_err) begin
            pci_stat_next[`SEN_PS_PCIPAR] = 1'b1;
        end
        pci_stat_next[7:2] = 6'h00;
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            cmd_lo_reg <= `SEN_RST_BYTE;
            cmd_hi_reg <= `SEN_RST_BYTE;
            sys_ctrl_reg <= `SEN_RST_BYTE;
            nmi_ctrl_reg <= `SEN_RST_BYTE;
            err_cmd_reg <= `SEN_RST_BYTE;
            err_stat_reg <= `SEN_RST_BYTE;
            route_reg <= `SEN_RST_BYTE;
            pci_stat_reg <= `SEN_RST_BYTE;
        end else begin
            cmd_lo_reg <= cmd_lo_next;
            cmd_hi_reg <= cmd_hi_next;
            sys_ctrl_reg <= sys_ctrl_next;
            nmi_ctrl_reg <= nmi_ctrl_next;
            err_cmd_reg <= err_cmd_next;
            err_stat_reg <= err_stat_next;
            route_reg <= route_next;
            pci_stat_reg <= pci_stat_next;
        end
    end

    // ============================================================
    // serr, perr and nmi outputs
    logic serr_cause;
    logic serr_next;
    logic perr_next;
    logic nmi_next;
    logic serr_oe_n_reg;
    logic perr_oe_n_reg;
    logic nmi_reg;

    // processor bus faults have no path into this sum
    always_comb begin
        serr_cause = (pci_stat_reg[`SEN_PS_TABORT] & err_cmd_reg[`SEN_EC_TABORT])
            | (pci_stat_reg[`SEN_PS_PCIPAR] & err_cmd_reg[`SEN_EC_PCIPAR])
            | (err_stat_reg[`SEN_ES_MBE] & err_cmd_reg[`SEN_EC_MBE])
            | (err_stat_reg[`SEN_ES_SBE] & err_cmd_reg[`SEN_EC_SBE])
            | ~i_sec_serr_n;
        serr_next = serr_cause & cmd_hi_reg[`SEN_HI_SERR_EN];
        perr_next = ~i_sec_perr_n & cmd_lo_reg[`SEN_LO_PERR_EN];
        nmi_next = ~nmi_ctrl_reg[`SEN_NC_MASK] & (sys_ctrl_reg[`SEN_SC_MEM_FLAG]
            | sys_ctrl_reg[`SEN_SC_CHK_FLAG]
            | (~serr_oe_n_reg & route_reg[`SEN_RT_SERR_NMI]));
    end

    // enables kept active low in the flops so the pins need no gate after them
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            serr_oe_n_reg <= 1'b1;
            perr_oe_n_reg <= 1'b1;
            nmi_reg <= 1'b0;
        end else begin
            serr_oe_n_reg <= ~serr_next;
            perr_oe_n_reg <= ~perr_next;
            nmi_reg <= nmi_next;
        end
    end

    // open-drain pins: value always low, enable low while pulling
    assign o_serr_o = 1'b0;
    assign o_perr_o = 1'b0;
    assign o_serr_oe_n = serr_oe_n_reg;
    assign o_perr_oe_n = perr_oe_n_reg;
    assign o_nmi = nmi_reg;
    assign o_hreadyout = hreadyout_reg;
    assign o_hresp = 1'b0;
    assign o_hrdata = hrdata_reg;

endmodule : sen_top

/* verilog/sen_defs.svh */
// register indices, field positions, reset values for the system error block
// assumes inclusion by bare name from the top module and the bench
`ifndef SEN_DEFS_SVH
`define SEN_DEFS_SVH

// ============================================================
// register indices (byte address = index * 4)
`define SEN_IDX_PCI_CMD_LO 10'h004
`define SEN_IDX_PCI_CMD_HI 10'h005
`define SEN_IDX_SYS_CTRL 10'h061
`define SEN_IDX_NMI_CTRL 10'h070
`define SEN_IDX_ERR_CMD 10'h090
`define SEN_IDX_ERR_STAT 10'h091
`define SEN_IDX_ERR_ROUTE 10'h092
`define SEN_IDX_PCI_STAT 10'h093

// ============================================================
// field positions
`define SEN_LO_PERR_EN 6
`define SEN_HI_SERR_EN 1
`define SEN_SC_MEM_FLAG 7
`define SEN_SC_CHK_FLAG 6
`define SEN_SC_CHK_EN 3
`define SEN_SC_PAR_EN 2
`define SEN_NC_MASK 7
`define SEN_EC_TABORT 4
`define SEN_EC_PCIPAR 3
`define SEN_EC_MBE 1
`define SEN_EC_SBE 0
`define SEN_ES_MBE_ROW_HI 7
`define SEN_ES_MBE_ROW_LO 5
`define SEN_ES_MBE 4
`define SEN_ES_SBE_ROW_HI 3
`define SEN_ES_SBE_ROW_LO 1
`define SEN_ES_SBE 0
`define SEN_RT_SERR_NMI 0
`define SEN_PS_TABORT 0
`define SEN_PS_PCIPAR 1

// ============================================================
// reset values and masks
`define SEN_RST_BYTE 8'h00
`define SEN_SC_WR_MASK 8'h0c
`define SEN_RT_WR_MASK 8'h01

`endif

/* verilog/sen_pkg.sv */
// types shared by the system error block
// assumes sen_defs.svh is on the include path
package sen_pkg;

    // ============================================================
    // bus slave state, one-hot
    typedef enum logic [1:0] {
        SEN_ST_IDLE = 2'b01,
        SEN_ST_DATA = 2'b10
    } sen_bus_st_t;

    typedef logic [7:0] sen_byte_t;

endpackage : sen_pkg

/* verification/sen_top_assertions.sv */
// checker for the system error block, bound onto sen_top
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ps

module sen_top_assertions (
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire logic i_hsel,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic i_hready,
    input wire logic o_hreadyout,
    input wire logic o_hresp,
    input wire logic i_sec_serr_n,
    input wire logic i_sec_perr_n,
    input wire logic o_serr_o,
    input wire logic o_serr_oe_n,
    input wire logic o_perr_o,
    input wire logic o_perr_oe_n,
    input wire logic o_nmi
);
    // ============================================================
    // helper: recent writes, the only thing allowed to clear a cause
    logic taken;
    logic wr_dp;
    logic [3:0] wr_hist;
    assign taken = i_hsel && i_htrans[1] && i_hready;
    always_ff @(posedge i_clk_sys) begin
        wr_dp <= !i_srst && taken && i_hwrite;
        wr_hist <= {wr_hist[2:0], wr_dp};
    end
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_srst);
    // ============================================================
    // assertions
    a_resp_okay: assert property (o_hresp == 1'b0)
        else $error("bus response not okay");
    a_one_wait: assert property (taken |=> !o_hreadyout ##1 o_hreadyout)
        else $error("register access not one wait state");
    a_no_stall: assert property (!taken && o_hreadyout |=> o_hreadyout)
        else $error("wait state without a request");
    a_drive_low: assert property (o_serr_o == 1'b0 && o_perr_o == 1'b0)
        else $error("error line driven high");
    a_perr_cause: assert property (!o_perr_oe_n |-> !$past(i_sec_perr_n))
        else $error("parity line pulled without secondary cause");
    a_perr_release: assert property ($rose(i_sec_perr_n) |=> o_perr_oe_n)
        else $error("parity line held after secondary release");
    a_serr_hold: assert property ($rose(o_serr_oe_n) |-> (|wr_hist) || $past(i_sec_serr_n))
        else $error("system error released on its own");
    a_nmi_hold: assert property ($fell(o_nmi) |->
        (|wr_hist) || $past(i_sec_serr_n) || $past(i_sec_serr_n, 2))
        else $error("nmi dropped on its own");
    c_write: cover property (taken && i_hwrite);
    c_nmi: cover property ($rose(o_nmi));
    c_perr: cover property ($fell(o_perr_oe_n));
endmodule : sen_top_assertions

bind sen_top sen_top_assertions sen_top_assertions_inst (
    .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_hsel(i_hsel), .i_htrans(i_htrans),
    .i_hwrite(i_hwrite), .i_hready(i_hready), .o_hreadyout(o_hreadyout),
    .o_hresp(o_hresp), .i_sec_serr_n(i_sec_serr_n), .i_sec_perr_n(i_sec_perr_n),
    .o_serr_o(o_serr_o), .o_serr_oe_n(o_serr_oe_n), .o_perr_o(o_perr_o),
    .o_perr_oe_n(o_perr_oe_n), .o_nmi(o_nmi)
);

/* verification/sen_pci_host.sv */
// processor nmi pin and pci agents on the error lines
// assumes open-drain lines with pull-ups; agents commanded by the bench
`timescale 1ns/1ps

module sen_pci_host (
    input wire logic i_serr_o,
    input wire logic i_serr_oe_n,
    input wire logic i_perr_o,
    input wire logic i_perr_oe_n,
    input wire logic i_nmi,
    input wire logic i_drive_serr,
    input wire logic i_drive_perr,
    output logic o_serr_line,
    output logic o_perr_line,
    output logic o_sec_serr_n,
    output logic o_sec_perr_n,
    output logic o_nmi_seen
);
    // ============================================================
    // pull-up wins whenever nobody pulls
    assign o_serr_line = i_serr_oe_n ? 1'b1 : i_serr_o;
    assign o_perr_line = i_perr_oe_n ? 1'b1 : i_perr_o;
    // secondary agent reports by pulling its lines
    assign o_sec_serr_n = !i_drive_serr;
    assign o_sec_perr_n = !i_drive_perr;
    assign o_nmi_seen = i_nmi;
endmodule : sen_pci_host

/* verification/test_system_error_nmi_reporting.sv */
// bench: register table, error routes onto serr and nmi, reset
// assumes sen_top, sen_pci_host and the bound checker
`timescale 1ns/1ps
`include "sen_defs.svh"

module test_system_error_nmi_reporting;
    typedef struct packed {
        logic [9:0] idx;
        logic [7:0] wd;
        logic [7:0] rd;
    } sen_reg_case_t;
    typedef struct packed {
        logic [7:0] sc;
        logic [7:0] ec;
        logic rt;
        logic [2:0] src;
        logic [2:0] exp;
        logic [9:0] ridx;
        logic [7:0] rexp;
    } sen_evt_case_t;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic iochk_n = 1'b1;
    logic [5:1] ev = 5'h0;
    logic dserr = 1'b0;
    logic dperr = 1'b0;
    logic hready, serr_o, serr_oe_n, perr_o, perr_oe_n, nmi;
    logic serr_line, perr_line, sec_serr_n, sec_perr_n, nmi_seen;
    logic [31:0] hrdata;
    int fails = 0;
    int checks = 0;
    // ============================================================
    // tables: unmapped 3ff last; exp is {serr line, nmi, perr line}
    sen_reg_case_t regs [8] = '{'{10'h004, 8'hff, 8'hff}, '{10'h005, 8'hff, 8'hff},
        '{10'h061, 8'hff, 8'h0c}, '{10'h070, 8'hff, 8'hff}, '{10'h090, 8'hff, 8'hff},
        '{10'h091, 8'hff, 8'h00}, '{10'h092, 8'hff, 8'h01}, '{10'h3ff, 8'hff, 8'h00}};
    sen_evt_case_t evts [11] = '{
        '{8'h08, 8'h00, 1'b0, 3'd0, 3'h7, 10'h061, 8'h48},
        '{8'h00, 8'h00, 1'b0, 3'd0, 3'h5, 10'h061, 8'h00},
        '{8'h04, 8'h00, 1'b0, 3'd1, 3'h7, 10'h061, 8'h84},
        '{8'h00, 8'h10, 1'b0, 3'd2, 3'h1, 10'h093, 8'h01},
        '{8'h00, 8'h00, 1'b0, 3'd2, 3'h5, 10'h090, 8'h00},
        '{8'h00, 8'h08, 1'b0, 3'd3, 3'h1, 10'h093, 8'h02},
        '{8'h00, 8'h01, 1'b0, 3'd4, 3'h1, 10'h091, 8'h0b},
        '{8'h00, 8'h02, 1'b0, 3'd5, 3'h1, 10'h091, 8'hb0},
        '{8'h00, 8'h02, 1'b1, 3'd5, 3'h3, 10'h091, 8'hb0},
        '{8'h00, 8'h00, 1'b0, 3'd6, 3'h1, 10'h091, 8'h00},
        '{8'h00, 8'h00, 1'b0, 3'd7, 3'h4, 10'h091, 8'h00}};

    sen_top sen_top_inst (
        .i_clk_sys(clk), .i_srst(srst), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
        .i_hready(hready), .o_hreadyout(hready), .o_hresp(), .o_hrdata(hrdata),
        .i_iochk_n(iochk_n), .i_mem_parity_err(ev[1]), .i_pci_target_abort(ev[2]),
        .i_pci_parity_err(ev[3]), .i_ecc_sbe(ev[4]), .i_ecc_mbe(ev[5]), .i_ecc_row(3'h5),
        .i_sec_serr_n(sec_serr_n), .i_sec_perr_n(sec_perr_n), .o_serr_o(serr_o),
        .o_serr_oe_n(serr_oe_n), .o_perr_o(perr_o), .o_perr_oe_n(perr_oe_n), .o_nmi(nmi));
    sen_pci_host sen_pci_host_inst (
        .i_serr_o(serr_o), .i_serr_oe_n(serr_oe_n), .i_perr_o(perr_o),
        .i_perr_oe_n(perr_oe_n), .i_nmi(nmi), .i_drive_serr(dserr), .i_drive_perr(dperr),
        .o_serr_line(serr_line), .o_perr_line(perr_line), .o_sec_serr_n(sec_serr_n),
        .o_sec_perr_n(sec_perr_n), .o_nmi_seen(nmi_seen));

    initial begin
        forever #12.5 clk = ~clk;
    end
    // ============================================================
    // tasks
    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task bus(input logic w, input logic [9:0] idx, input logic [7:0] d, output logic [31:0] q);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {20'h0, idx, 2'h0};
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata;
    endtask : bus
    task wr(input logic [9:0] idx, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, idx, d, q);
    endtask : wr
    task rd(input logic [9:0] idx, input logic [7:0] e);
        logic [31:0] q;
        bus(1'b0, idx, 8'h00, q);
        check("rdata", q, {24'h0, e});
    endtask : rd
    task reset_dut;
        srst <= 1'b1;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
    endtask : reset_dut
    task give_verdict;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict
    // ============================================================
    // watchdog: about twenty-five times the expected run
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        give_verdict();
    end
    initial begin
        reset_dut();
        foreach (regs[i]) begin
            wr(regs[i].idx, regs[i].wd);
            rd(regs[i].idx, regs[i].rd);
        end
        foreach (evts[i]) begin
            reset_dut();
            wr(`SEN_IDX_PCI_CMD_HI, 8'h02);
            wr(`SEN_IDX_PCI_CMD_LO, 8'h40);
            wr(`SEN_IDX_SYS_CTRL, evts[i].sc);
            wr(`SEN_IDX_ERR_CMD, evts[i].ec);
            wr(`SEN_IDX_ERR_ROUTE, {7'h0, evts[i].rt});
            @(posedge clk);
            iochk_n <= evts[i].src != 3'd0;
            ev <= 5'h01 << (evts[i].src - 3'd1);
            dserr <= evts[i].src == 3'd6;
            dperr <= evts[i].src == 3'd7;
            @(posedge clk);
            iochk_n <= 1'b1;
            ev <= 5'h00;
            repeat (4) @(posedge clk);
            #1;
            check("lines", {29'h0, serr_line, nmi_seen, perr_line}, {29'h0, evts[i].exp});
            rd(evts[i].ridx, evts[i].rexp);
            dserr <= 1'b0;
            dperr <= 1'b0;
        end
        // mask hides a standing nmi, the flag survives it
        reset_dut();
        wr(`SEN_IDX_SYS_CTRL, 8'h04);
        @(posedge clk);
        ev <= 5'h01;
        @(posedge clk);
        ev <= 5'h00;
        wr(`SEN_IDX_NMI_CTRL, 8'h80);
        repeat (3) @(posedge clk);
        check("nmi masked", {31'h0, nmi_seen}, 32'h0);
        wr(`SEN_IDX_NMI_CTRL, 8'h00);
        repeat (3) @(posedge clk);
        check("nmi unmasked", {31'h0, nmi_seen}, 32'h1);
        wr(`SEN_IDX_SYS_CTRL, 8'h00);
        rd(`SEN_IDX_SYS_CTRL, 8'h00);
        check("nmi cleared", {31'h0, nmi_seen}, 32'h0);
        // write-one-to-clear keeps the row field
        wr(`SEN_IDX_PCI_CMD_HI, 8'h02);
        wr(`SEN_IDX_ERR_CMD, 8'h01);
        @(posedge clk);
        ev <= 5'h08;
        @(posedge clk);
        ev <= 5'h00;
        repeat (3) @(posedge clk);
        check("serr held", {31'h0, serr_line}, 32'h0);
        wr(`SEN_IDX_ERR_STAT, 8'h01);
        rd(`SEN_IDX_ERR_STAT, 8'h0a);
        check("serr released", {31'h0, serr_line}, 32'h1);
        // mid-run reset returns every register to zero
        reset_dut();
        foreach (regs[i]) begin
            rd(regs[i].idx, 8'h00);
        end
        give_verdict();
    end
endmodule : test_system_error_nmi_reporting
